// ### rtl/cbk_core.sv
// Return-address stack, shadow registers and banked data memory addressing.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "cbk_core_regs.svh"

module cbk_core #(
    parameter int PC_W = 21,
    parameter int STACK_DEPTH = 31,
    parameter logic [15:0] BANK_IMPL = 16'hffff,
    parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction sequencer requests, one-cycle pulses.
    input wire logic push_op,
    input wire logic pop_op,
    input wire logic call_op,
    input wire logic return_op,
    input wire logic return_from_interrupt_op,
    input wire logic int_vector_op,
    input wire logic op_fast,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic load_bank_literal_op,
    input wire logic [7:0] bank_literal,
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    // Restored values handed back to the sequencer.
    output logic restore_valid,
    output logic [7:0] restore_status,
    output logic [7:0] restore_working,
    // Stack state.
    output logic [PC_W-1:0] stack_top_entry,
    output logic stack_reset,
    output logic [3:0] bank_select_reg,
    // Data memory access port.
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_access_bank,
    input wire logic move_file_to_file_op,
    input wire logic [7:0] mem_operand,
    input wire logic [11:0] mem_full_addr,
    input wire logic [7:0] mem_wdata,
    output logic mem_rvalid,
    output logic [7:0] mem_rdata,
    output logic [11:0] mem_eff_addr
);

    // Number of banks and bytes per bank in the data space.
    localparam int BANKS = 16;
    localparam int BANK_BYTES = 256;

    // Stack pointer, full flag and underflow flag.
    logic [4:0] ptr_q;
    logic [4:0] ptr_d;
    logic full_q;
    logic full_d;
    logic under_q;
    logic under_d;
    // Stack error reset enable held in the config register.
    logic stvr_en_q;
    // Return-address storage; entry zero is never written.
    logic [PC_W-1:0] stack_mem [1:STACK_DEPTH];
    // Shadow copies, invisible to software.
    logic [7:0] sh_status_q;
    logic [7:0] sh_working_q;
    logic [3:0] sh_bank_q;
    // Bank select register and its next value.
    logic [3:0] bsr_q;
    logic [3:0] bsr_d;
    // Data memory, one array for the full space.
    logic [7:0] data_mem [0:BANKS*BANK_BYTES-1];

    // APB phase decode.
    logic apb_setup;
    logic apb_wr;
    logic ptr_wr;
    logic bsr_wr;
    logic cfg_wr;
    logic addr_ok;

    // Sequencer decode.
    cbk_core_pkg::cbk_stack_op_type stk_op;
    cbk_core_pkg::cbk_bsr_src_type bsr_src;
    logic do_push;
    logic do_pop;
    logic save_shadow;
    logic load_shadow;
    logic overflow_ev;
    logic became_full;
    logic under_ev;
    logic [11:0] eff_addr;
    logic bank_ok;

    // The setup phase is where the answer is prepared.
    assign apb_setup = psel & ~penable;
    // A write takes effect at the edge where pready is sampled high.
    assign apb_wr = psel & penable & pready & pwrite;
    assign ptr_wr = apb_wr && (paddr == `CBK_OFF_STACK_PTR);
    assign bsr_wr = apb_wr && (paddr == `CBK_OFF_BANK_SEL);
    assign cfg_wr = apb_wr && (paddr == `CBK_OFF_CONFIG);

    // Decode which addresses exist on the bus.
    always_comb begin
        unique case (paddr)
            `CBK_OFF_STACK_PTR: addr_ok = 1'b1;
            `CBK_OFF_BANK_SEL: addr_ok = 1'b1;
            `CBK_OFF_CONFIG: addr_ok = 1'b1;
            `CBK_OFF_STACK_TOP: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Calls and interrupt entry push; returns pop; explicit ops as well.
    assign do_push = push_op | call_op | int_vector_op;
    assign do_pop = pop_op | return_op | return_from_interrupt_op;

    // Any interrupt vectoring, or a fast call, saves the shadows.
    assign save_shadow = int_vector_op | (call_op & op_fast);
    // A fast return of either kind restores them.
    assign load_shadow = (return_op | return_from_interrupt_op) & op_fast;

    // Classify the stack movement of this cycle.
    always_comb begin
        if (do_push) begin
            stk_op = cbk_core_pkg::CBK_STK_PUSH;
        end else if (do_pop) begin
            stk_op = cbk_core_pkg::CBK_STK_POP;
        end else begin
            stk_op = cbk_core_pkg::CBK_STK_HOLD;
        end
    end

    // A push at the top overflows and writes nothing.
    assign overflow_ev = (stk_op == cbk_core_pkg::CBK_STK_PUSH)
        && (ptr_q == 5'(STACK_DEPTH));
    // A push that lands on the last entry makes the stack full.
    assign became_full = (stk_op == cbk_core_pkg::CBK_STK_PUSH)
        && (ptr_q == 5'(STACK_DEPTH - 1));
    // A pop of an empty stack underflows.
    assign under_ev = (stk_op == cbk_core_pkg::CBK_STK_POP)
        && (ptr_q == 5'h00);

    // Next stack pointer: sequencer movement wins over a software write.
    always_comb begin
        ptr_d = ptr_q;
        unique case (stk_op)
            cbk_core_pkg::CBK_STK_PUSH: begin
                if (!overflow_ev) begin
                    ptr_d = ptr_q + 5'h01;
                end
            end
            cbk_core_pkg::CBK_STK_POP: begin
                if (!under_ev) begin
                    ptr_d = ptr_q - 5'h01;
                end
            end
            cbk_core_pkg::CBK_STK_HOLD: begin
                if (ptr_wr) begin
                    ptr_d = pwdata[`CBK_PTR_MSB:0];
                end
            end
            default: ptr_d = ptr_q;
        endcase
    end

    // Flags: software can only clear, and a new event beats the clear.
    always_comb begin
        full_d = full_q;
        under_d = under_q;
        if (ptr_wr && !pwdata[`CBK_FULL_BIT]) begin
            full_d = 1'b0;
        end
        if (ptr_wr && !pwdata[`CBK_UNDER_BIT]) begin
            under_d = 1'b0;
        end
        if (overflow_ev || became_full) begin
            full_d = 1'b1;
        end
        if (under_ev) begin
            under_d = 1'b1;
        end
    end

    // Stack pointer and flags; reset clears all three.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= 5'h00;
            full_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            ptr_q <= ptr_d;
            full_q <= full_d;
            under_q <= under_d;
        end
    end

    // Write the pushed PC into the newly addressed entry.
    always_ff @(posedge pclk) begin
        if ((stk_op == cbk_core_pkg::CBK_STK_PUSH) && !overflow_ev) begin
            stack_mem[ptr_q + 5'h01] <= pc_in;
        end
    end

    // Top-of-stack output follows the new pointer; empty shows zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_top_entry <= '0;
        end else if ((stk_op == cbk_core_pkg::CBK_STK_PUSH) && !overflow_ev) begin
            stack_top_entry <= pc_in;
        end else if (ptr_d == 5'h00) begin
            stack_top_entry <= '0;
        end else begin
            stack_top_entry <= stack_mem[ptr_d];
        end
    end

    // A full or underflow event requests a device reset only if enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_reset <= 1'b0;
        end else begin
            stack_reset <= stvr_en_q
                & (overflow_ev | became_full | under_ev);
        end
    end

    // Stack error reset enable, written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stvr_en_q <= `CBK_RST_CONFIG;
        end else if (cfg_wr) begin
            stvr_en_q <= pwdata[`CBK_STVR_EN_BIT];
        end
    end

    // Shadow copies: a single level, each save overwrites the last.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_status_q <= 8'h00;
            sh_working_q <= 8'h00;
            sh_bank_q <= 4'h0;
        end else if (save_shadow) begin
            sh_status_q <= status_in;
            sh_working_q <= working_register_in;
            sh_bank_q <= bsr_q;
        end
    end

    // Restored status and working values go back to the sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restore_valid <= 1'b0;
            restore_status <= 8'h00;
            restore_working <= 8'h00;
        end else begin
            restore_valid <= load_shadow;
            if (load_shadow) begin
                restore_status <= sh_status_q;
                restore_working <= sh_working_q;
            end
        end
    end

    // Bank select source: shadow restore, then literal, then bus.
    always_comb begin
        if (load_shadow) begin
            bsr_src = cbk_core_pkg::CBK_BSR_SHADOW;
        end else if (load_bank_literal_op) begin
            bsr_src = cbk_core_pkg::CBK_BSR_LITERAL;
        end else if (bsr_wr) begin
            bsr_src = cbk_core_pkg::CBK_BSR_BUS;
        end else begin
            bsr_src = cbk_core_pkg::CBK_BSR_KEEP;
        end
    end

    // Only the low nibble is stored; the upper bits are dropped.
    always_comb begin
        unique case (bsr_src)
            cbk_core_pkg::CBK_BSR_SHADOW: bsr_d = sh_bank_q;
            cbk_core_pkg::CBK_BSR_LITERAL: bsr_d = bank_literal[3:0];
            cbk_core_pkg::CBK_BSR_BUS: bsr_d = pwdata[3:0];
            cbk_core_pkg::CBK_BSR_KEEP: bsr_d = bsr_q;
            default: bsr_d = bsr_q;
        endcase
    end

    // Bank select register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsr_q <= `CBK_RST_BANK_SEL;
        end else begin
            bsr_q <= bsr_d;
        end
    end

    // The bank select output mirrors the register.
    assign bank_select_reg = bsr_q;

    // Effective data address from the addressing mode.
    always_comb begin
        if (move_file_to_file_op) begin
            eff_addr = mem_full_addr;
        end else if (mem_access_bank) begin
            // Low operands hit bank zero, high ones the register bank.
            if (mem_operand < ACCESS_SPLIT) begin
                eff_addr = {4'h0, mem_operand};
            end else begin
                eff_addr = {4'hf, mem_operand};
            end
        end else begin
            eff_addr = {bsr_q, mem_operand};
        end
    end

    // Whether the addressed bank exists.
    assign bank_ok = BANK_IMPL[eff_addr[11:8]];

    // Writes to missing banks are discarded.
    always_ff @(posedge pclk) begin
        if (mem_req && mem_we && bank_ok) begin
            data_mem[eff_addr] <= mem_wdata;
        end
    end

    // Every access completes; missing banks read zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 8'h00;
            mem_eff_addr <= 12'h000;
        end else begin
            mem_rvalid <= mem_req;
            if (mem_req) begin
                mem_eff_addr <= eff_addr;
                if (bank_ok && !mem_we) begin
                    mem_rdata <= data_mem[eff_addr];
                end else begin
                    mem_rdata <= 8'h00;
                end
            end
        end
    end

    // APB answer, prepared in the setup phase; no wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            prdata <= 32'h0000_0000;
            if (apb_setup && !pwrite) begin
                unique case (paddr)
                    `CBK_OFF_STACK_PTR: begin
                        // Bit five is absent and reads zero.
                        prdata <= {24'h000000, full_q, under_q, 1'b0,
                            ptr_q};
                    end
                    `CBK_OFF_BANK_SEL: begin
                        prdata <= {28'h0000000, bsr_q};
                    end
                    `CBK_OFF_CONFIG: begin
                        prdata <= {31'h00000000, stvr_en_q};
                    end
                    `CBK_OFF_STACK_TOP: begin
                        prdata <= 32'(stack_top_entry);
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : cbk_core

// ### rtl/cbk_core_pkg.sv
// Types shared by the core stack and bank addressing block.
package cbk_core_pkg;

    // Kind of movement the return-address stack makes in one cycle.
    typedef enum logic [1:0] {
        CBK_STK_HOLD = 2'b00,
        CBK_STK_PUSH = 2'b01,
        CBK_STK_POP = 2'b11
    } cbk_stack_op_type;

    // Source of the next bank select value.
    typedef enum logic [1:0] {
        CBK_BSR_KEEP = 2'b00,
        CBK_BSR_SHADOW = 2'b01,
        CBK_BSR_LITERAL = 2'b11,
        CBK_BSR_BUS = 2'b10
    } cbk_bsr_src_type;

endpackage : cbk_core_pkg

// ### rtl/cbk_core_regs.svh
// Register offsets, field positions and reset values of the core stack block.
// Functional notes
// - Push increments pointer, writes PC to top.
// - Pop decrements pointer, discarding the top entry.
// - Pointer is five-bit field, software read/write.
// - Full flag in bit seven on full/overflow.
// - Underflow flag in bit six on underflow.
// - Flags reset zero, software clears only, sticky.
// - Bit five of pointer register reads zero.
// - Flag always set; reset only when enabled.
// - One hidden shadow copy per saved register.
// - Interrupt vectoring saves status, working, bank select.
// - Fast interrupt return restores the three registers.
// - Later interrupt overwrites shadow; single level only.
// - Fast call saves shadows and pushes return.
// - Fast return restores shadows and pops address.
// - Twelve-bit data addresses, sixteen banks of 256.
// - Unimplemented locations read as all zeros.
// - Access window reaches registers without bank select.
// - Banked address is bank select over operand.
// - Bank select upper nibble reads zero, ignores writes.
// - Load-bank-literal loads bank select from literal.
// - Unimplemented banks drop writes, read zero, succeed.
// - File-to-file move uses full addresses, ignores bank.
`ifndef CBK_CORE_REGS_SVH
`define CBK_CORE_REGS_SVH

// Byte offsets of the APB registers.
`define CBK_OFF_STACK_PTR 12'h000
`define CBK_OFF_BANK_SEL 12'h004
`define CBK_OFF_CONFIG 12'h008
`define CBK_OFF_STACK_TOP 12'h00c

// Field positions inside the stack pointer register.
`define CBK_FULL_BIT 7
`define CBK_UNDER_BIT 6
`define CBK_PTR_MSB 4

// Field position of the stack error reset enable in the config register.
`define CBK_STVR_EN_BIT 0

// Reset values.
`define CBK_RST_STACK_PTR 8'h00
`define CBK_RST_BANK_SEL 4'h0
`define CBK_RST_CONFIG 1'b0

`endif

// ### tb/cbk_core_bench.sv
// Self-checking bench of the core stack and bank addressing block.
`timescale 1ns/1ps
`include "cbk_core_regs.svh"
module cbk_core_bench;
    // Banks 14 and 15 are left out to reach the missing-bank paths.
    localparam logic [15:0] IMPL = 16'h3fff;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic push_op, pop_op, call_op, return_op, return_from_interrupt_op;
    logic int_vector_op, op_fast, restore_valid, stack_reset;
    logic [20:0] pc_in, top;
    logic [7:0] status_in, working_register_in, r_st, r_wk;
    logic [3:0] bank_select;
    logic lit_op = 1'b0, mem_req = 1'b0, mem_we = 1'b0, acc = 1'b0;
    logic mff = 1'b0, mem_rvalid;
    logic [7:0] lit = 8'h0, opnd = 8'h0, wd = 8'h0, mem_rdata, d;
    logic [11:0] fadr = 12'h0, mem_eff_addr, ef, ef2;
    // Reference model: stack, pointer, bank select and shadows.
    logic [20:0] stk [0:31];
    int sp = 0, bad_count = 0, comparisons = 0;
    logic en = 1'b0, rst_e;
    logic [3:0] bsr_m = 4'h0, sh_b;
    logic [7:0] sh_s, sh_w;

    always #5 pclk = ~pclk;

    cbk_core #(.BANK_IMPL(IMPL)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .push_op, .pop_op, .call_op, .return_op,
        .return_from_interrupt_op, .int_vector_op, .op_fast, .pc_in,
        .load_bank_literal_op(lit_op), .bank_literal(lit), .status_in,
        .working_register_in, .restore_valid, .restore_status(r_st),
        .restore_working(r_wk), .stack_top_entry(top), .stack_reset,
        .bank_select_reg(bank_select), .mem_req, .mem_we, .mem_access_bank(acc),
        .move_file_to_file_op(mff), .mem_operand(opnd), .mem_full_addr(fadr),
        .mem_wdata(wd), .mem_rvalid, .mem_rdata, .mem_eff_addr
    );

    cbk_seq_model seq (
        .pclk, .restore_valid, .restore_status(r_st), .restore_working(r_wk),
        .push_op, .pop_op, .call_op, .return_op, .return_from_interrupt_op,
        .int_vector_op, .op_fast, .pc_in, .status_in, .working_register_in
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // Counts one comparison and reports a mismatch.
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h saw %h", n, e, s);
        end
    endtask : chk

    // One APB transfer; waits for pready under a bound.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] dd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 8) begin
            bad_count++;
            report_and_stop();
        end
    endtask : apb

    // Loads bank select from a literal.
    task automatic lit_load(input logic [7:0] v);
        @(posedge pclk);
        lit_op <= 1'b1;
        lit <= v;
        @(posedge pclk);
        lit_op <= 1'b0;
        bsr_m = v[3:0];
    endtask : lit_load

    // One sequencer request, predicted by the model, then checked.
    task automatic step(input int k, input logic f);
        logic [20:0] pc;
        pc = 21'($urandom);
        rst_e = 1'b0;
        if (k == 5 || (k == 2 && f)) begin
            sh_s = seq.status_q;
            sh_w = seq.working_q;
            sh_b = bsr_m;
        end
        if (k == 0 || k == 2 || k == 5) begin
            if (sp == 31) rst_e = 1'b1;
            else begin
                sp++;
                stk[sp] = pc;
                rst_e = (sp == 31);
            end
        end else if (sp == 0) rst_e = 1'b1;
        else sp--;
        if ((k == 3 || k == 4) && f) bsr_m = sh_b;
        seq.op(k, f, pc);
        // The reset request stands only in the cycle after the request.
        @(negedge pclk);
        chk("top", (sp == 0) ? 21'h0 : stk[sp], top);
        chk("reset", rst_e && en, stack_reset);
        chk("bank", bsr_m, bank_select);
        if ((k == 3 || k == 4) && f) begin
            chk("status", sh_s, r_st);
            chk("working", sh_w, r_wk);
        end
        // Let the sequencer adopt restored values before the next request.
        @(posedge pclk);
    endtask : step

    // One data access: mode 0 banked, 1 access window, 2 full address.
    task automatic mem(input logic w, input int m, input logic [7:0] o,
        input logic [11:0] a, input logic [7:0] e, output logic [11:0] x);
        x = (m == 2) ? a : (m == 1) ? {(o < 8'h80) ? 4'h0 : 4'hf, o}
            : {bsr_m, o};
        @(posedge pclk);
        mem_req <= 1'b1;
        mem_we <= w;
        acc <= (m == 1);
        mff <= (m == 2);
        opnd <= o;
        fadr <= a;
        wd <= e;
        @(posedge pclk);
        mem_req <= 1'b0;
        @(negedge pclk);
        chk("addr", x, mem_eff_addr);
        chk("rvalid", 1'b1, mem_rvalid);
        chk("rdata", (w || !IMPL[x[11:8]]) ? 8'h00 : e, mem_rdata);
    endtask : mem

    initial begin
        void'($urandom(62356));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CBK_OFF_STACK_PTR, 32'h0);
        chk("ptr reset", 32'h0, rdat);
        apb(1'b0, `CBK_OFF_BANK_SEL, 32'h0);
        chk("bank reset", 32'h0, rdat);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 1'b1, rerr);
        for (int i = 0; i < 32; i++) step(0, 1'b0);
        apb(1'b0, `CBK_OFF_STACK_PTR, 32'h0);
        chk("full", 32'h9f, rdat);
        apb(1'b1, `CBK_OFF_STACK_PTR, 32'he5);
        apb(1'b0, `CBK_OFF_STACK_PTR, 32'h0);
        chk("sticky", 32'h85, rdat);
        sp = 5;
        chk("written top", stk[5], top);
        apb(1'b1, `CBK_OFF_STACK_PTR, 32'h05);
        for (int i = 0; i < 6; i++) step(1, 1'b0);
        apb(1'b0, `CBK_OFF_STACK_PTR, 32'h0);
        chk("underflow", 32'h40, rdat);
        apb(1'b1, `CBK_OFF_CONFIG, 32'h1);
        apb(1'b0, `CBK_OFF_CONFIG, 32'h0);
        chk("config", 32'h1, rdat);
        en = 1'b1;
        step(1, 1'b0);
        apb(1'b1, `CBK_OFF_CONFIG, 32'h0);
        en = 1'b0;
        apb(1'b1, `CBK_OFF_STACK_PTR, 32'h0);
        seq.set_regs(8'h11, 8'h22);
        lit_load(8'h03);
        step(5, 1'b0);
        seq.set_regs(8'h33, 8'h44);
        lit_load(8'hf7);
        step(5, 1'b0);
        seq.set_regs(8'h55, 8'h66);
        lit_load(8'h09);
        step(4, 1'b1);
        seq.set_regs(8'h77, 8'h88);
        lit_load(8'h05);
        step(2, 1'b1);
        lit_load(8'h02);
        step(3, 1'b1);
        apb(1'b0, `CBK_OFF_STACK_TOP, 32'h0);
        chk("top reg", stk[sp], rdat);
        apb(1'b1, `CBK_OFF_BANK_SEL, 32'hff);
        apb(1'b0, `CBK_OFF_BANK_SEL, 32'h0);
        chk("bank upper", 32'h0f, rdat);
        bsr_m = 4'hf;
        for (int i = 0; i < 30; i++) begin
            lit_load(8'($urandom));
            d = 8'($urandom);
            mem(1'b1, i % 3, 8'($urandom), 12'($urandom), d, ef);
            mem(1'b0, 2, 8'h00, ef, d, ef2);
        end
        report_and_stop();
    end
endmodule : cbk_core_bench

// ### tb/cbk_core_checker.sv
// Concurrent checks on the ports of the core stack block.
`timescale 1ns/1ps
module cbk_core_checker #(
    parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic return_op,
    input wire logic return_from_interrupt_op,
    input wire logic op_fast,
    input wire logic restore_valid,
    input wire logic load_bank_literal_op,
    input wire logic [7:0] bank_literal,
    input wire logic [3:0] bank_select_reg,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_access_bank,
    input wire logic move_file_to_file_op,
    input wire logic [7:0] mem_operand,
    input wire logic [11:0] mem_full_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    input wire logic [11:0] mem_eff_addr
);
    // All checks run on the one clock and pause during reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A fast return takes bank select away from a literal load.
    wire fast_ret = (return_op || return_from_interrupt_op) && op_fast;
    // A fast return hands back the shadows in a one-cycle pulse.
    a_restore_pulse: assert property (fast_ret |=> restore_valid ##1 !restore_valid)
        else $error("restore pulse wrong");
    a_literal_load: assert property (load_bank_literal_op && !fast_ret |=>
        {4'h0, bank_select_reg} == ($past(bank_literal) & 8'h0f))
        else $error("literal not loaded");
    a_banked_addr: assert property (mem_req && !mem_access_bank &&
        !move_file_to_file_op |=> mem_eff_addr ==
        {$past(bank_select_reg), $past(mem_operand)})
        else $error("banked address wrong");
    a_window_addr: assert property (mem_req && mem_access_bank &&
        !move_file_to_file_op |=> mem_eff_addr ==
        {($past(mem_operand) < ACCESS_SPLIT) ? 4'h0 : 4'hf,
        $past(mem_operand)})
        else $error("window address wrong");
    a_full_addr: assert property (mem_req && move_file_to_file_op |=>
        mem_eff_addr == $past(mem_full_addr))
        else $error("full address wrong");
    a_rvalid_next: assert property (mem_req |=> mem_rvalid)
        else $error("no data answer");
    a_write_zero: assert property (mem_req && mem_we |=> mem_rdata == 8'h00)
        else $error("write returned data");
    a_ready_next: assert property (psel && !penable |=> pready && psel)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
endmodule : cbk_core_checker

bind cbk_core cbk_core_checker #(.ACCESS_SPLIT(ACCESS_SPLIT)) chk_i (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .return_op,
    .return_from_interrupt_op, .op_fast, .restore_valid,
    .load_bank_literal_op, .bank_literal, .bank_select_reg, .mem_req,
    .mem_we, .mem_access_bank, .move_file_to_file_op, .mem_operand,
    .mem_full_addr, .mem_rdata, .mem_rvalid, .mem_eff_addr
);

// ### tb/cbk_seq_model.sv
// Sequencer stand-in: issues stack requests, holds status and working.
`timescale 1ns/1ps
module cbk_seq_model (
    input wire logic pclk,
    input wire logic restore_valid,
    input wire logic [7:0] restore_status,
    input wire logic [7:0] restore_working,
    output logic push_op = 1'b0,
    output logic pop_op = 1'b0,
    output logic call_op = 1'b0,
    output logic return_op = 1'b0,
    output logic return_from_interrupt_op = 1'b0,
    output logic int_vector_op = 1'b0,
    output logic op_fast = 1'b0,
    output logic [20:0] pc_in = 21'h0,
    output logic [7:0] status_in,
    output logic [7:0] working_register_in
);
    // Status and working registers live on this side.
    logic [7:0] status_q = 8'h00;
    logic [7:0] working_q = 8'h00;
    assign status_in = status_q;
    assign working_register_in = working_q;

    // Adopt the values a fast return hands back.
    always @(posedge pclk) begin
        if (restore_valid === 1'b1) begin
            status_q <= restore_status;
            working_q <= restore_working;
        end
    end

    // Loads new register values at a clock edge.
    task automatic set_regs(input logic [7:0] st, input logic [7:0] wk);
        @(posedge pclk);
        status_q <= st;
        working_q <= wk;
    endtask : set_regs

    // Issues one request: 0 push, 1 pop, 2 call, 3 return, 4 int return,
    // 5 vector. The pc is inverted once released so stale values show.
    task automatic op(input int k, input logic f, input logic [20:0] pc);
        @(posedge pclk);
        {int_vector_op, return_from_interrupt_op, return_op, call_op,
            pop_op, push_op} <= 6'h01 << k;
        op_fast <= f;
        pc_in <= pc;
        @(posedge pclk);
        {int_vector_op, return_from_interrupt_op, return_op, call_op,
            pop_op, push_op} <= 6'h00;
        op_fast <= 1'b0;
        pc_in <= ~pc;
    endtask : op
endmodule : cbk_seq_model
